// ---- test/dbm_drop_clock_src.sv ----
`timescale 1ns/1ps
module dbm_drop_clock_src #(
	parameter int HALF_NS = 80
) (
	input wire logic run,
	output logic dropBusClock
);
	// clock stands low between bursts, so a stalled source shows no edges
	initial begin
		dropBusClock = 1'b0;
		#3;
		forever begin
			#(HALF_NS);
			dropBusClock = run ? ~dropBusClock : 1'b0;
		end
	end
endmodule : dbm_drop_clock_src

// ---- test/dbm_output_mux_tb.sv ----
`timescale 1ns/1ps
module dbm_output_mux_tb import dbm_pkg::*; ;
	logic clock, reset = 1'b1, regWrite = 1'b0, regRead = 1'b0;
	logic [ADDR_W-1:0] regAddr = '0;
	logic [DATA_W-1:0] regWrData = '0, rdv, regRdData;
	logic [DROP_W-1:0] dropWordIn = '0, dropBusDataCh2, pW = '0, w;
	logic dropWordValid = 1'b0, dropWordReady, dropClk, run = 1'b0;
	logic bit2 = 1'b0, bit10 = 1'b0, rdy2, rdy10, dataCh2, clk10;
	logic mon = 1'b0, dmon = 1'b0, fall2, fall10, pD2, pC2, pD10, pC10;
	logic [DROP_W-1:0] exq[$];
	int errors = 0, samplesChecked = 0, tog;

	dbm_output_mux i_dut (.clock(clock), .reset(reset), .regAddr(regAddr),
		.regWrData(regWrData), .regWrite(regWrite), .regRead(regRead),
		.regRdData(regRdData), .dropWordIn(dropWordIn), .dropWordValid(dropWordValid),
		.dropWordReady(dropWordReady), .dropBusClockCh2(dropClk), .lineBitCh2(bit2),
		.lineBitValidCh2(1'b1), .lineBitReadyCh2(rdy2), .lineBitCh10(bit10),
		.lineBitValidCh10(1'b1), .lineBitReadyCh10(rdy10),
		.dropBusDataCh2(dropBusDataCh2), .lineDataOutCh2(dataCh2),
		.lineClockOutCh10(clk10));
	dbm_drop_clock_src i_src (.run(run), .dropBusClock(dropClk));

	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end

	task automatic check(input string n, input logic [7:0] e, input logic [7:0] g);
		samplesChecked++;
		if (g !== e) begin
			errors++;
			$display("mismatch %s exp %h got %h", n, e, g);
		end
	endtask : check

	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		@(posedge clock);
		regWrite <= 1'b1;
		regAddr <= a;
		regWrData <= d;
		@(posedge clock);
		regWrite <= 1'b0;
	endtask : wr

	task automatic rd(input logic [15:0] a);
		@(posedge clock);
		regRead <= 1'b1;
		regAddr <= a;
		@(posedge clock);
		regRead <= 1'b0;
		#1 rdv = regRdData;
	endtask : rd

	task automatic rdchk(input logic [15:0] a, input logic [7:0] e);
		rd(a);
		check("reg read", e, rdv);
	endtask : rdchk

	// toggling sources make every update edge visible at the pins
	always @(posedge clock) begin
		if (rdy2)
			bit2 <= ~bit2;
		if (rdy10)
			bit10 <= ~bit10;
	end

	always @(posedge clock) begin
		if (mon) begin
			check("spare pins", 8'h00, dropBusDataCh2 & 8'hcf);
			if (dataCh2 !== pD2) begin
				tog++;
				check("ch2 edge", fall2 ? 8'h02 : 8'h01, {6'h0, pC2, dropBusDataCh2[5]});
			end
			if (dropBusDataCh2[4] !== pD10) begin
				tog++;
				check("ch10 edge", fall10 ? 8'h02 : 8'h01, {6'h0, pC10, clk10});
			end
		end
		if (dmon && dropBusDataCh2 !== pW && exq.size() > 0)
			check("drop word", exq.pop_front(), dropBusDataCh2);
		pD2 <= dataCh2;
		pC2 <= dropBusDataCh2[5];
		pD10 <= dropBusDataCh2[4];
		pC10 <= clk10;
		pW <= dropBusDataCh2;
	end

	task automatic phase(input logic [7:0] pin, input logic [7:0] inv, input logic f);
		wr(PIN_CTRL_OFFSET, pin);
		wr(IO_CTRL_CH2_OFFSET, inv);
		wr(IO_CTRL_CH10_OFFSET, inv);
		fall2 = f;
		fall10 = f;
		// a mode change may glitch, so let it settle first
		repeat (16) @(posedge clock);
		tog = 0;
		mon = 1'b1;
		repeat (80) @(posedge clock);
		mon = 1'b0;
		check("line toggles", 8'h01, {7'h0, tog > 10});
		$display("test line mode %h %h done", pin, inv);
	endtask : phase

	task automatic results;
		$display("checks %0d mismatches %0d", samplesChecked, errors);
		if (errors == 0 && samplesChecked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : results

	initial begin
		#100_000;
		errors++;
		results;
	end

	initial begin
		repeat (16) @(posedge clock);
		reset <= 1'b0;
		@(posedge clock);
		rdchk(IO_CTRL_CH2_OFFSET, IO_CTRL_RESET);
		rdchk(IO_CTRL_CH10_OFFSET, IO_CTRL_RESET);
		rdchk(PIN_CTRL_OFFSET, PIN_CTRL_RESET);
		wr(16'h2222, 8'hff);
		rdchk(16'h2222, READ_ZERO);
		wr(IO_CTRL_CH10_OFFSET, 8'ha5);
		rdchk(IO_CTRL_CH10_OFFSET, 8'ha5);
		$display("test registers done");
		phase(8'h00, 8'h00, 1'b0);
		phase(8'h00, 8'h01, 1'b1);
		phase(8'h06, 8'h01, 1'b0);
		// drop bus still off: nothing drains, so the buffer must refuse
		for (int i = 0; i < 16; i++) begin
			w = {i[3:0], ~i[3:0]};
			exq.push_back(w);
			@(posedge clock);
			dropWordIn <= w;
			dropWordValid <= 1'b1;
		end
		@(posedge clock);
		dropWordValid <= 1'b0;
		#1 check("word ready", 8'h00, {7'h0, dropWordReady});
		rd(PIN_STATUS_OFFSET);
		check("fifo full", 8'h02, rdv & 8'h0b);
		wr(PIN_CTRL_OFFSET, 8'h01);
		repeat (4) @(posedge clock);
		#1 check("drop idle", DROP_WORD_RESET, dropBusDataCh2);
		dmon = 1'b1;
		run <= 1'b1;
		for (int k = 0; k < 400 && exq.size() > 0; k++)
			@(posedge clock);
		check("words left", 8'h00, 8'(exq.size()));
		run <= 1'b0;
		dmon = 1'b0;
		rd(PIN_STATUS_OFFSET);
		check("fifo empty", 8'h09, rdv & 8'h0b);
		$display("test drop bus done");
		results;
	end
endmodule : dbm_output_mux_tb

// ---- verilog/dbm_output_mux.sv ----
// Overview of operation
// - bus enable picks each shared pin's function
// - enabled: pins carry drop data bits 4,5
// - drop data changes only on drop clock rise
// - disabled: first pin outputs channel 10 line data
// - disabled: second pin outputs channel 2 line clock
// - line data changes on line clock rise
// - ch2 invert bit selects falling edge, DS3/E3
// - ch10 invert bit selects falling edge, DS3/E3
// - STS-1 mode ignores invert, rising edge only
`timescale 1ns/1ps

module dbm_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16
) (
	input wire logic clock,
	input wire logic reset,
	input wire logic [WIDTH-1:0] inData,
	input wire logic inValid,
	output logic inReady,
	output logic [WIDTH-1:0] outData,
	output logic outValid,
	input wire logic outReady
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0] wrPtr_reg;
	logic [AW:0] rdPtr_reg;
	logic pushing;
	logic popping;

	assign outValid = wrPtr_reg != rdPtr_reg;
	assign inReady = (wrPtr_reg[AW-1:0] != rdPtr_reg[AW-1:0]) || (wrPtr_reg[AW] == rdPtr_reg[AW]);
	assign pushing = inValid && inReady;
	assign popping = outValid && outReady;
	assign outData = mem[rdPtr_reg[AW-1:0]];

	always_ff @(posedge clock) begin
		if (pushing) begin
			mem[wrPtr_reg[AW-1:0]] <= inData;
		end
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			wrPtr_reg <= '0;
			rdPtr_reg <= '0;
		end else begin
			if (pushing) begin
				wrPtr_reg <= wrPtr_reg + (AW+1)'(1);
			end
			if (popping) begin
				rdPtr_reg <= rdPtr_reg + (AW+1)'(1);
			end
		end
	end
endmodule : dbm_fifo

module dbm_output_mux
	import dbm_pkg::*;
#(
	parameter int HALF_CYCLES = LINE_HALF_CYCLES,
	parameter int DEPTH = FIFO_DEPTH
) (
	input wire logic clock,
	input wire logic reset,
	input wire logic [ADDR_W-1:0] regAddr,
	input wire logic [DATA_W-1:0] regWrData,
	input wire logic regWrite,
	input wire logic regRead,
	output logic [DATA_W-1:0] regRdData,
	input wire logic [DROP_W-1:0] dropWordIn,
	input wire logic dropWordValid,
	output logic dropWordReady,
	input wire logic dropBusClockCh2,
	input wire logic lineBitCh2,
	input wire logic lineBitValidCh2,
	output logic lineBitReadyCh2,
	input wire logic lineBitCh10,
	input wire logic lineBitValidCh10,
	output logic lineBitReadyCh10,
	output logic [DROP_W-1:0] dropBusDataCh2,
	output logic lineDataOutCh2,
	output logic lineClockOutCh10
);
	logic [DATA_W-1:0] ioCtrlCh2_reg;
	logic [DATA_W-1:0] ioCtrlCh10_reg;
	logic [DATA_W-1:0] pinCtrl_reg;
	logic [DATA_W-1:0] regRdData_reg;
	logic [DATA_W-1:0] regRdData_next;
	logic dropClkMeta_reg;
	logic dropClkSync_reg;
	logic dropClkPrev_reg;
	logic dropRise;
	logic [DROP_W-1:0] dropWord_reg;
	logic [DROP_W-1:0] fifoData;
	logic fifoValid;
	logic fifoPop;
	logic [7:0] lineCount_reg;
	logic lineClock_reg;
	logic lineToggle;
	logic lineRise;
	logic lineFall;
	logic lineDataCh2_reg;
	logic lineDataCh10_reg;
	logic updateCh2;
	logic updateCh10;
	dbm_pin_fn_t pinFunction;
	logic [DROP_W-1:0] dropPins_reg;
	logic lineDataOut_reg;
	logic lineClockOut_reg;

	// edge choice shared by both channels; STS-1 forces the rising edge
	function automatic logic lineUpdate(
		input logic rise,
		input logic fall,
		input logic invert,
		input logic sts1
	);
		return (invert && !sts1) ? fall : rise;
	endfunction : lineUpdate

	// register port
	always_ff @(posedge clock) begin
		if (reset) begin
			ioCtrlCh2_reg <= IO_CTRL_RESET;
			ioCtrlCh10_reg <= IO_CTRL_RESET;
			pinCtrl_reg <= PIN_CTRL_RESET;
		end else if (regWrite) begin
			case (regAddr)
				IO_CTRL_CH2_OFFSET: begin
					ioCtrlCh2_reg <= regWrData;
				end
				IO_CTRL_CH10_OFFSET: begin
					ioCtrlCh10_reg <= regWrData;
				end
				PIN_CTRL_OFFSET: begin
					pinCtrl_reg <= regWrData;
				end
				default: begin
				end
			endcase
		end
	end

	always_comb begin
		regRdData_next = READ_ZERO;
		case (regAddr)
			IO_CTRL_CH2_OFFSET: begin
				regRdData_next = ioCtrlCh2_reg;
			end
			IO_CTRL_CH10_OFFSET: begin
				regRdData_next = ioCtrlCh10_reg;
			end
			PIN_CTRL_OFFSET: begin
				regRdData_next = pinCtrl_reg;
			end
			PIN_STATUS_OFFSET: begin
				regRdData_next[ST_FIFO_EMPTY_BIT] = !fifoValid;
				regRdData_next[ST_FIFO_FULL_BIT] = !dropWordReady;
				regRdData_next[ST_LINE_CLOCK_BIT] = lineClock_reg;
				regRdData_next[ST_PIN_FUNCTION_BIT] = pinFunction;
			end
			default: begin
				regRdData_next = READ_ZERO;
			end
		endcase
	end

	// read data stands only in the cycle after the strobe
	always_ff @(posedge clock) begin
		if (reset) begin
			regRdData_reg <= READ_ZERO;
		end else if (regRead) begin
			regRdData_reg <= regRdData_next;
		end else begin
			regRdData_reg <= READ_ZERO;
		end
	end

	assign regRdData = regRdData_reg;

	// pin selection is treated as static set-up, not retimed to either clock
	assign pinFunction = pinCtrl_reg[DROP_ENABLE_BIT] ? PIN_FN_DROP : PIN_FN_LINE;

	// drop bus clock comes from a pin: two flops before any logic looks at it
	always_ff @(posedge clock) begin
		if (reset) begin
			dropClkMeta_reg <= 1'b0;
			dropClkSync_reg <= 1'b0;
			dropClkPrev_reg <= 1'b0;
		end else begin
			dropClkMeta_reg <= dropBusClockCh2;
			dropClkSync_reg <= dropClkMeta_reg;
			dropClkPrev_reg <= dropClkSync_reg;
		end
	end

	assign dropRise = dropClkSync_reg && !dropClkPrev_reg;

	dbm_fifo #(
		.WIDTH(DROP_W),
		.DEPTH(DEPTH)
	) u_dropFifo (
		.clock(clock),
		.reset(reset),
		.inData(dropWordIn),
		.inValid(dropWordValid),
		.inReady(dropWordReady),
		.outData(fifoData),
		.outValid(fifoValid),
		.outReady(fifoPop)
	);

	// the fifo drains only on drop clock rises, so a slow bus clock stalls the source
	assign fifoPop = (pinFunction == PIN_FN_DROP) && dropRise;

	// an empty fifo on a rise holds the previous word rather than inventing one
	always_ff @(posedge clock) begin
		if (reset) begin
			dropWord_reg <= DROP_WORD_RESET;
		end else if (fifoPop && fifoValid) begin
			dropWord_reg <= fifoData;
		end
	end

	// line clock divider, shared by channels 2 and 10
	assign lineToggle = lineCount_reg == 8'(HALF_CYCLES - 1);
	assign lineRise = lineToggle && !lineClock_reg;
	assign lineFall = lineToggle && lineClock_reg;

	always_ff @(posedge clock) begin
		if (reset) begin
			lineCount_reg <= 8'h00;
			lineClock_reg <= 1'b0;
		end else if (lineToggle) begin
			lineCount_reg <= 8'h00;
			lineClock_reg <= !lineClock_reg;
		end else begin
			lineCount_reg <= lineCount_reg + 8'h01;
		end
	end

	assign updateCh2 = lineUpdate(lineRise, lineFall, ioCtrlCh2_reg[CLK_INVERT_BIT],
		pinCtrl_reg[STS1_CH2_BIT]);
	assign updateCh10 = lineUpdate(lineRise, lineFall, ioCtrlCh10_reg[CLK_INVERT_BIT],
		pinCtrl_reg[STS1_CH10_BIT]);
	assign lineBitReadyCh2 = updateCh2;
	assign lineBitReadyCh10 = updateCh10;

	// a missing source bit sends zero for that line bit
	always_ff @(posedge clock) begin
		if (reset) begin
			lineDataCh2_reg <= 1'b0;
		end else if (updateCh2) begin
			lineDataCh2_reg <= lineBitValidCh2 && lineBitCh2;
		end
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			lineDataCh10_reg <= 1'b0;
		end else if (updateCh10) begin
			lineDataCh10_reg <= lineBitValidCh10 && lineBitCh10;
		end
	end

	// one output stage for every pin keeps clock and data aligned at the pins
	always_ff @(posedge clock) begin
		if (reset) begin
			dropPins_reg <= DROP_WORD_RESET;
			lineDataOut_reg <= 1'b0;
			lineClockOut_reg <= 1'b0;
		end else begin
			lineDataOut_reg <= lineDataCh2_reg;
			lineClockOut_reg <= lineClock_reg;
			if (pinFunction == PIN_FN_DROP) begin
				dropPins_reg <= dropWord_reg;
			end else begin
				dropPins_reg <= DROP_WORD_RESET;
				dropPins_reg[4] <= lineDataCh10_reg;
				dropPins_reg[5] <= lineClock_reg;
			end
		end
	end

	assign dropBusDataCh2 = dropPins_reg;
	assign lineDataOutCh2 = lineDataOut_reg;
	assign lineClockOutCh10 = lineClockOut_reg;

	default clocking cb @(posedge clock);
	endclocking
	default disable iff (reset);

	AST_PIN_FUNCTION_SELECT: assert property (
		$stable(pinFunction) |=> dropBusDataCh2[4] ==
			($past(pinFunction) == PIN_FN_DROP ? $past(dropWord_reg[4]) : $past(lineDataCh10_reg)))
		else $error("shared pin 4 does not follow the selected function");

	AST_DROP_WORD_REACHES_PINS: assert property (
		(fifoPop && fifoValid && pinFunction == PIN_FN_DROP) ##1 (pinFunction == PIN_FN_DROP)
			|=> dropBusDataCh2 == $past(fifoData, 2))
		else $error("drop word did not reach the bus pins two cycles after the rise");

	AST_DROP_CHANGE_ONLY_ON_RISE: assert property (
		$changed(dropWord_reg) |-> $past(dropRise) && $past(pinFunction) == PIN_FN_DROP)
		else $error("drop word changed without a drop clock rise");

	AST_CH10_DATA_ON_PIN: assert property (
		(pinFunction == PIN_FN_LINE) [*2] |-> dropBusDataCh2[4] == $past(lineDataCh10_reg))
		else $error("pin 4 does not carry channel 10 line data");

	AST_CH2_CLOCK_ON_PIN: assert property (
		(pinFunction == PIN_FN_LINE) [*2]
			|-> dropBusDataCh2[5] == $past(lineClock_reg))
		else $error("pin 5 does not carry the channel 2 line clock");

	AST_CH10_EDGE_CHOICE: assert property (
		$changed(lineDataCh10_reg) |->
			(($past(ioCtrlCh10_reg[CLK_INVERT_BIT]) && !$past(pinCtrl_reg[STS1_CH10_BIT]))
				? $fell(lineClock_reg) : $rose(lineClock_reg)))
		else $error("channel 10 line data changed on the wrong clock edge");

	AST_CH2_EDGE_CHOICE: assert property (
		$changed(lineDataCh2_reg) |->
			(($past(ioCtrlCh2_reg[CLK_INVERT_BIT]) && !$past(pinCtrl_reg[STS1_CH2_BIT]))
				? $fell(lineClock_reg) : $rose(lineClock_reg)))
		else $error("channel 2 line data changed on the wrong clock edge");

	AST_STS1_RISE_ONLY: assert property (
		(pinCtrl_reg[STS1_CH2_BIT] && lineBitReadyCh2) |=> $rose(lineClock_reg))
		else $error("STS-1 channel 2 line data taken away from a rising edge");

	AST_STS1_RISE_ONLY_CH10: assert property (
		(pinCtrl_reg[STS1_CH10_BIT] && lineBitReadyCh10) |=> $rose(lineClock_reg))
		else $error("STS-1 channel 10 line data taken away from a rising edge");

	AST_CH2_PIN_ALIGNED: assert property (
		$changed(lineDataOutCh2) |-> $changed(lineClockOutCh10))
		else $error("channel 2 data pin changed between line clock edges");
endmodule : dbm_output_mux

// ---- verilog/dbm_pkg.sv ----
package dbm_pkg;
	localparam int ADDR_W = 16;
	localparam int DATA_W = 8;
	localparam int DROP_W = 8;

	localparam logic [ADDR_W-1:0] IO_CTRL_CH2_OFFSET = 16'h3F01;
	localparam logic [ADDR_W-1:0] IO_CTRL_CH10_OFFSET = 16'hBF01;
	localparam logic [ADDR_W-1:0] PIN_CTRL_OFFSET = 16'h0100;
	localparam logic [ADDR_W-1:0] PIN_STATUS_OFFSET = 16'h0101;

	localparam int CLK_INVERT_BIT = 0;
	localparam int DROP_ENABLE_BIT = 0;
	localparam int STS1_CH2_BIT = 1;
	localparam int STS1_CH10_BIT = 2;

	localparam int ST_FIFO_EMPTY_BIT = 0;
	localparam int ST_FIFO_FULL_BIT = 1;
	localparam int ST_LINE_CLOCK_BIT = 2;
	localparam int ST_PIN_FUNCTION_BIT = 3;

	localparam logic [DATA_W-1:0] IO_CTRL_RESET = 8'h00;
	localparam logic [DATA_W-1:0] PIN_CTRL_RESET = 8'h00;
	localparam logic [DATA_W-1:0] READ_ZERO = 8'h00;
	localparam logic [DROP_W-1:0] DROP_WORD_RESET = 8'h00;

	localparam int CLOCK_PERIOD_NS = 10;
	localparam int LINE_HALF_PERIOD_NS = 40;
	localparam int LINE_HALF_CYCLES = (LINE_HALF_PERIOD_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;

	localparam int FIFO_DEPTH = 16;

	typedef enum logic {
		PIN_FN_LINE = 1'b0,
		PIN_FN_DROP = 1'b1
	} dbm_pin_fn_t;
endpackage : dbm_pkg
